// ### uht_defs.vh
// Register offsets, field positions and reset values of the token and configuration block.
`ifndef UHT_DEFS_VH
`define UHT_DEFS_VH
`define UHT_OFS_ADDR 5'h00
`define UHT_OFS_TOK 5'h04
`define UHT_OFS_SOF 5'h08
`define UHT_OFS_CNFG1 5'h0C
`define UHT_OFS_CNFG2 5'h10
`define UHT_OFS_STAT 5'h14
`define UHT_BIT_LOWSPD 7
`define UHT_BIT_EYE 7
`define UHT_BIT_OEMON 6
`define UHT_BIT_SIDL 4
`define UHT_BIT_TRDIS 0
`define UHT_BIT_BUSY 0
`define UHT_BIT_DEFER 1
`define UHT_PID_SETUP 4'hD
`define UHT_PID_IN 4'h9
`define UHT_PID_OUT 4'h1
`define UHT_SOF_BASE 8'h0A
`define UHT_RST_BYTE 8'h00
`define UHT_TOKEN_CYCLES 8'h20
`endif

// ### uht_regbank.v
// Small register bank holding the eight-bit register images.
`timescale 1ns/1ps
module uht_regbank #(
  parameter AW = 3,
  parameter DW = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i,
  input wire [AW-1:0] raddr_i,
  output reg [DW-1:0] rdata_o
);
  reg [DW-1:0] mem_reg [0:(1<<AW)-1];
  genvar g;
  // ****************************************
  // Storage entries.
  // ****************************************
  generate
    for (g = 0; g < (1<<AW); g = g + 1) begin : g_ent
      always @(posedge clk_i) begin
        if (rst_i) begin
          mem_reg[g] <= {DW{1'b0}};
        end else if (we_i && waddr_i == g) begin
          mem_reg[g] <= wdata_i;
        end
      end
    end
  endgenerate
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= {DW{1'b0}};
    end else begin
      rdata_o <= mem_reg[raddr_i];
    end
  end
endmodule // uht_regbank

// ### uht_token_regs.v
// Host token, address, threshold and configuration registers with a Wishbone slave.
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "uht_defs.vh"
module uht_token_regs (
  input wire clk_i,
  input wire rst_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire host_mode_i,
  input wire cpu_idle_i,
  input wire [15:0] frame_left_i,
  input wire line_drive_i,
  output reg [6:0] bus_address_o,
  output reg low_speed_o,
  output reg token_start_o,
  output reg [3:0] token_type_o,
  output reg [3:0] token_endpoint_o,
  output reg eye_test_o,
  output reg drive_monitor_n_o,
  output reg module_halt_o,
  output reg transceiver_ext_o,
  output reg [1:0] pingpong_select_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_RUN = 3'b100;
  reg host_meta_reg;
  reg host_sync_reg;
  reg idle_meta_reg;
  reg idle_sync_reg;
  reg drive_meta_reg;
  reg drive_sync_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] run_cnt_reg;
  reg [7:0] run_cnt_next;
  reg tok_pend_reg;
  reg ack_pend_reg;
  reg [2:0] rsel_reg;
  reg tok_write;
  reg [7:0] wbyte;
  reg [7:0] rd_fix;
  wire access;
  wire wr_ok;
  wire [2:0] index;
  wire [7:0] bank_rd;
  wire [7:0] addr_img;
  wire [7:0] tok_img;
  wire [7:0] sof_img;
  wire [7:0] cnfg1_img;
  wire [7:0] cnfg2_img;
  wire tok_valid;
  wire frame_ok;
  wire halted;
  // ****************************************
  // Input synchronisers.
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      host_meta_reg <= 1'b0;
      host_sync_reg <= 1'b0;
      idle_meta_reg <= 1'b0;
      idle_sync_reg <= 1'b0;
      drive_meta_reg <= 1'b0;
      drive_sync_reg <= 1'b0;
    end else begin
      host_meta_reg <= host_mode_i;
      host_sync_reg <= host_meta_reg;
      idle_meta_reg <= cpu_idle_i;
      idle_sync_reg <= idle_meta_reg;
      drive_meta_reg <= line_drive_i;
      drive_sync_reg <= drive_meta_reg;
    end
  end
  // ****************************************
  // Wishbone decode.
  // ****************************************
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o && !ack_pend_reg;
  assign index = {wb_adr_i[4], wb_adr_i[3:2]};
  assign wr_ok = access && wb_we_i && wb_sel_i[0] && (wb_adr_i[31:5] == 27'h0);
  always @* begin
    wbyte = wb_dat_i[7:0];
    tok_write = 1'b0;
    case (index)
      3'd0: begin
        if (!host_sync_reg) begin
          wbyte[`UHT_BIT_LOWSPD] = 1'b0;
        end
      end
      3'd1: begin
        tok_write = wr_ok && host_sync_reg;
      end
      3'd3: begin
        wbyte = wb_dat_i[7:0] & 8'hD3;
      end
      3'd4: begin
        wbyte = wb_dat_i[7:0] & 8'h3F;
      end
      default: begin
        wbyte = wb_dat_i[7:0];
      end
    endcase
  end
  uht_regbank #(.AW(3), .DW(8)) u_bank (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(wr_ok && (index != 3'd1 || tok_write) && index != 3'd5),
    .waddr_i(index),
    .wdata_i(wbyte),
    .raddr_i(index),
    .rdata_o(bank_rd)
  );
  // ****************************************
  // Register images kept beside the bank.
  // ****************************************
  reg [7:0] addr_reg;
  reg [7:0] tok_reg;
  reg [7:0] sof_reg;
  reg [7:0] cnfg1_reg;
  reg [7:0] cnfg2_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      addr_reg <= `UHT_RST_BYTE;
      tok_reg <= `UHT_RST_BYTE;
      sof_reg <= `UHT_RST_BYTE;
      cnfg1_reg <= `UHT_RST_BYTE;
      cnfg2_reg <= `UHT_RST_BYTE;
    end else if (wr_ok) begin
      case (index)
        3'd0: addr_reg <= wbyte;
        3'd1: begin
          if (tok_write) begin
            tok_reg <= wbyte;
          end
        end
        3'd2: sof_reg <= wbyte;
        3'd3: cnfg1_reg <= wbyte;
        3'd4: cnfg2_reg <= wbyte;
        default: addr_reg <= addr_reg;
      endcase
    end else if (!host_sync_reg) begin
      addr_reg[`UHT_BIT_LOWSPD] <= 1'b0;
    end
  end
  assign addr_img = addr_reg;
  assign tok_img = tok_reg;
  assign sof_img = sof_reg;
  assign cnfg1_img = cnfg1_reg;
  assign cnfg2_img = cnfg2_reg;
  // ****************************************
  // Token sequencer.
  // ****************************************
  // defined token codes
  assign tok_valid = (tok_img[7:4] == `UHT_PID_SETUP) || (tok_img[7:4] == `UHT_PID_IN) ||
    (tok_img[7:4] == `UHT_PID_OUT);
  assign frame_ok = frame_left_i >= {8'h00, sof_img};
  assign halted = cnfg1_img[`UHT_BIT_SIDL] && idle_sync_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      tok_pend_reg <= 1'b0;
    end else if (tok_write && tok_valid_w(wbyte)) begin
      tok_pend_reg <= 1'b1;
    end else if (state_reg == ST_WAIT && state_next == ST_RUN) begin
      tok_pend_reg <= 1'b0;
    end
  end
  function tok_valid_w;
    input [7:0] b;
    begin
      tok_valid_w = (b[7:4] == `UHT_PID_SETUP) || (b[7:4] == `UHT_PID_IN) ||
        (b[7:4] == `UHT_PID_OUT);
    end
  endfunction
  always @* begin
    state_next = state_reg;
    run_cnt_next = run_cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (tok_pend_reg && host_sync_reg) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!host_sync_reg) begin
          state_next = ST_IDLE;
        end else if (frame_ok && !halted && tok_valid) begin
          state_next = ST_RUN;
          run_cnt_next = `UHT_TOKEN_CYCLES;
        end
      end
      ST_RUN: begin
        if (!halted) begin
          run_cnt_next = run_cnt_reg - 8'h01;
          if (run_cnt_reg == 8'h01) begin
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end
  // ****************************************
  // Outputs and read path.
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      run_cnt_reg <= 8'h00;
      token_start_o <= 1'b0;
      token_type_o <= 4'h0;
      token_endpoint_o <= 4'h0;
      bus_address_o <= 7'h00;
      low_speed_o <= 1'b0;
      eye_test_o <= 1'b0;
      drive_monitor_n_o <= 1'b1;
      module_halt_o <= 1'b0;
      transceiver_ext_o <= 1'b0;
      pingpong_select_o <= 2'b00;
    end else begin
      state_reg <= state_next;
      run_cnt_reg <= run_cnt_next;
      token_start_o <= (state_reg == ST_WAIT) && (state_next == ST_RUN);
      token_type_o <= tok_img[7:4];
      token_endpoint_o <= tok_img[3:0];
      bus_address_o <= addr_img[6:0];
      low_speed_o <= addr_img[`UHT_BIT_LOWSPD] && host_sync_reg;
      eye_test_o <= cnfg1_img[`UHT_BIT_EYE];
      drive_monitor_n_o <= !(cnfg1_img[`UHT_BIT_OEMON] && cnfg2_img[`UHT_BIT_TRDIS] &&
        drive_sync_reg);
      module_halt_o <= halted;
      transceiver_ext_o <= cnfg2_img[`UHT_BIT_TRDIS];
      pingpong_select_o <= cnfg1_img[1:0];
    end
  end
  always @* begin
    case (index)
      3'd0: rd_fix = host_sync_reg ? addr_img : (addr_img & 8'h7F);
      3'd1: rd_fix = tok_img;
      3'd2: rd_fix = sof_img;
      3'd3: rd_fix = cnfg1_img;
      3'd4: rd_fix = cnfg2_img;
      3'd5: rd_fix = {6'h00, !frame_ok, state_reg != ST_IDLE};
      default: rd_fix = 8'h00;
    endcase
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ack_pend_reg <= 1'b0;
      rsel_reg <= 3'd0;
    end else begin
      wb_ack_o <= access;
      ack_pend_reg <= access;
      rsel_reg <= index;
      if (access && !wb_we_i && wb_adr_i[31:5] == 27'h0) begin
        wb_dat_o <= {24'h000000, rd_fix};
      end else if (access) begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end
endmodule // uht_token_regs

// ### uht_token_regs_sva.sv
// Checker for the token and configuration register block.
`timescale 1ns/1ps
module uht_chk (
  input logic clk_i,
  input logic rst_i,
  input logic [31:0] wb_adr_i,
  input logic [31:0] wb_dat_i,
  input logic [3:0] wb_sel_i,
  input logic wb_we_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input logic host_mode_i,
  input logic [6:0] bus_address_o,
  input logic low_speed_o,
  input logic token_start_o,
  input logic [3:0] token_type_o,
  input logic drive_monitor_n_o,
  input logic transceiver_ext_o
);
  logic [6:0] adr_seen;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // Assertions.
  // ****
  always_ff @(posedge clk_i) begin
    if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 32'h0) begin
      adr_seen <= wb_dat_i[6:0];
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_ack_o);
  endsequence
  sequence s_adr_wr;
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 32'h0 ##2 1'h1;
  endsequence
  property p_ack; s_req |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_upper; wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_adr; s_adr_wr |-> bus_address_o == adr_seen; endproperty
  a_adr: assert property (p_adr) else $error("address not stored");
  property p_code; token_start_o |-> token_type_o inside {4'hD, 4'h9, 4'h1}; endproperty
  a_code: assert property (p_code) else $error("bad token code");
  property p_gap; token_start_o |=> !token_start_o [*8]; endproperty
  a_gap: assert property (p_gap) else $error("token restart");
  property p_mon; !drive_monitor_n_o |-> transceiver_ext_o || $past(transceiver_ext_o); endproperty
  a_mon: assert property (p_mon) else $error("monitor without ext");
  property p_spd; !host_mode_i [*4] |=> !low_speed_o; endproperty
  a_spd: assert property (p_spd) else $error("low speed in device mode");
endmodule // uht_chk
bind uht_token_regs uht_chk uht_chk_i (.*);

// ### uht_usb_peer.sv
// Attached peripheral model marking line drive intervals per token.
`timescale 1ns/1ps
module uht_usb_peer #(parameter int DRV = 6, parameter int EP_N = 4) (
  input logic clk_i,
  input logic rst_i,
  input logic start_i,
  input logic [3:0] type_i,
  input logic [3:0] ep_i,
  output logic drive_o,
  output logic bad_ep_o
);
  int cnt;
  initial drive_o = 1'h0;
  // ****
  // Token response.
  // ****
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 0;
      drive_o <= 1'h0;
      bad_ep_o <= 1'h0;
    end else begin
      if (start_i) begin
        cnt <= (type_i == 4'h9) ? DRV : 2 * DRV;
        bad_ep_o <= bad_ep_o | (ep_i >= EP_N);
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
      drive_o <= start_i || cnt > 1;
    end
  end
endmodule // uht_usb_peer

// ### tb.sv
// Self-checking bench for the token and configuration registers.
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'h0, rst_i = 1'h1, wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic host_mode_i = 1'h1, cpu_idle_i = 1'h0, line_drive_i, low_speed_o, token_start_o;
  logic wb_ack_o, eye_test_o, drive_monitor_n_o, module_halt_o, transceiver_ext_o, bad_ep, f;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, v, rq;
  logic [15:0] frame_left_i = 16'h0;
  logic [6:0] bus_address_o;
  logic [3:0] wb_sel_i = 4'h0, token_type_o, token_endpoint_o;
  logic [3:0] codes [3] = '{4'hD, 4'h9, 4'h1};
  logic [1:0] pingpong_select_o;
  int seed = 3462, error_cnt = 0, n_tests = 0;
  always #12.5 clk_i = ~clk_i;
  uht_token_regs uht_token_regs_i (.*);
  uht_usb_peer uht_usb_peer_i (.clk_i(clk_i), .rst_i(rst_i), .start_i(token_start_o),
    .type_i(token_type_o), .ep_i(token_endpoint_o), .drive_o(line_drive_i), .bad_ep_o(bad_ep));
  // ****
  // Tasks.
  // ****
  function automatic [31:0] adr_exp(input [7:0] d, input h);
    return {24'h0, d[7] & h, d[6:0]};
  endfunction
  task automatic chk(input [31:0] s, input [31:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic xfer(input [31:0] a, input [31:0] d, input w);
    int t;
    t = 0;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    @(posedge clk_i);
    while (wb_ack_o !== 1'h1 && t < 50) begin
      @(posedge clk_i);
      t++;
    end
    if (t == 50) error_cnt++;
    rq = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic rd(input [31:0] a, input [31:0] e);
    xfer(a, 32'h0, 1'h0);
    chk(rq, e);
  endtask
  task automatic wt(input int n);
    f = 1'h0;
    for (int i = 0; i < n && !f; i++) begin
      @(posedge clk_i);
      f = token_start_o === 1'h1;
    end
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****
  // Sequence.
  // ****
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    for (int a = 0; a < 24; a += 4) rd(a, 32'h0);
    $display("reset values done");
    repeat (4) begin
      v = $random(seed);
      xfer(32'h0, v, 1'h1);
      rd(32'h0, adr_exp(v[7:0], 1'h1));
      chk(low_speed_o, v[7]);
      chk(bus_address_o, v[6:0]);
    end
    xfer(32'h0, 32'hFFFF_FF85, 1'h1);
    host_mode_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    rd(32'h0, 32'h05);
    xfer(32'h04, 32'h91, 1'h1);
    rd(32'h04, 32'h0);
    rd(32'h20, 32'h0);
    host_mode_i <= 1'h1;
    $display("address register done");
    for (int p = 0; p < 4; p++) begin
      v = $random(seed);
      v[1:0] = p;
      xfer(32'h0C, v, 1'h1);
      rd(32'h0C, {24'h0, v[7:0] & 8'hD3});
      chk(pingpong_select_o, p);
      chk(eye_test_o, v[7]);
    end
    xfer(32'h0C, 32'h10, 1'h1);
    cpu_idle_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    chk(module_halt_o, 1'h1);
    xfer(32'h0C, 32'h40, 1'h1);
    repeat (3) @(posedge clk_i);
    chk(module_halt_o, 1'h0);
    cpu_idle_i <= 1'h0;
    $display("config register done");
    xfer(32'h08, 32'h12, 1'h1);
    for (int i = 0; i < 3; i++) begin
      frame_left_i <= 16'h0011;
      xfer(32'h10, i != 1, 1'h1);
      chk(transceiver_ext_o, i != 1);
      v = $random(seed) & 32'h3;
      xfer(32'h04, {codes[i], v[3:0]}, 1'h1);
      wt(20);
      chk(f, 1'h0);
      rd(32'h14, 32'h3);
      frame_left_i <= 16'h0012;
      wt(20);
      chk(f, 1'h1);
      chk(token_type_o, codes[i]);
      chk(token_endpoint_o, v[3:0]);
      repeat (5) @(posedge clk_i);
      chk(drive_monitor_n_o, i == 1);
      repeat (40) @(posedge clk_i);
    end
    xfer(32'h04, 32'h55, 1'h1);
    wt(20);
    chk(f, 1'h0);
    rd(32'h04, 32'h55);
    chk(bad_ep, 1'h0);
    $display("token tests done");
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    for (int a = 0; a < 24; a += 4) rd(a, 32'h0);
    chk(drive_monitor_n_o, 1'h1);
    chk(eye_test_o, 1'h0);
    chk(transceiver_ext_o, 1'h0);
    $display("reset test done");
    end_of_test();
  end
endmodule // tb
